// ==== src/pcg_pkg.sv ====
// Purpose: Constants for the PLL clock generator control block
// Assumes: Byte-wide register port, offsets local to this block
// Notes: Reset values and field positions live here only
package pcg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_CTRL = 3'h0;
    localparam logic [2:0] OFF_BW = 3'h1;
    localparam logic [2:0] OFF_MUL_HI = 3'h2;
    localparam logic [2:0] OFF_MUL_LO = 3'h3;
    localparam logic [2:0] OFF_VRS = 3'h4;
    localparam logic [2:0] OFF_RDS = 3'h5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_IE_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_ON_BIT = 5;
    localparam int CTRL_BCS_BIT = 4;
    localparam int CTRL_PRE_LSB = 2;
    localparam int CTRL_VPR_LSB = 0;

    // ------------------------------------------------------------
    // Bandwidth register fields
    // ------------------------------------------------------------
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_ACQ_BIT = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_ON = 1'b1;
    localparam logic [3:0] RST_MUL_HI = 4'h0;
    localparam logic [7:0] RST_MUL_LO = 8'h40;
    localparam logic [7:0] RST_VRS = 8'h40;
    localparam logic [3:0] RST_RDS = 4'h1;
    localparam logic [11:0] MUL_ZERO = 12'h000;
    localparam logic [11:0] MUL_ONE = 12'h001;
    localparam logic [3:0] RDS_ZERO = 4'h0;
    localparam logic [3:0] RDS_ONE = 4'h1;
    localparam logic [7:0] VRS_ZERO = 8'h00;

endpackage : pcg_pkg

// ==== src/pcg_top.sv ====
// Purpose: Digital control of a PLL clock generator behind a byte register port
// Assumes: Clock source inputs are sampled on core_clk_i, lock comes from the analog loop
// Notes: Outputs are registered, so each effect shows at least one cycle after its cause
//
// Behaviour
// - Auto mode: acquisition bit read-only, loop-driven
// - Manual mode: acquisition bit software read/write
// - Manual value held and restored after auto
// - Acquisition bit one is tracking, reset zero
// - Twelve-bit multiplier, zero behaves as one
// - Multiplier writes ignored while PLL on
// - Upper nibbles of high and divider zero
// - VCO range writes blocked while PLL on
// - Zero range disables PLL, clears select
// - VCO range resets to hex 40
// - Zero reference divider behaves as one
// - Auto mode lock change raises enabled interrupt
// - Flag sets regardless of enable; manual reads zero
// - VCO select not gated on lock
// - Wait mode changes nothing here
// - Stop without osc option silences everything
// - Stop clears select, stays clear after
// - Stop with osc option stops PLL only
// - Break without clear-enable protects the flag
// - Control register read clears the flag
// - Select needs PLL on; on held by select
// - Base clock is half selected source
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps

module pcg_top #(
    parameter int ADDR_W = 3
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    // Analog loop and oscillator
    input wire logic crystal_clock_i,
    input wire logic vco_clock_i,
    input wire logic lock_i,
    input wire logic loop_tracking_i,
    // System integration unit
    input wire logic stop_mode_i,
    input wire logic osc_run_in_stop_i,
    input wire logic break_state_i,
    input wire logic break_clear_enable_i,
    // Clock and interrupt outputs
    output logic crystal_clock_out_o,
    output logic base_clock_out_o,
    output logic pll_interrupt_out_o,
    // Loop configuration outputs
    output logic pll_enable_o,
    output logic osc_enable_o,
    output logic auto_bandwidth_o,
    output logic acquisition_mode_bit_o,
    output logic [11:0] feedback_multiplier_o,
    output logic [7:0] vco_range_multiplier_o,
    output logic [3:0] reference_divider_value_o,
    output logic [1:0] prescale_o,
    output logic [1:0] vco_power_range_o
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (ADDR_W < 3) begin : g_addr_chk
        $error("pcg_top: ADDR_W must be at least 3");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic pll_irq_enable;
        logic pll_lock_change_flag;
        logic pll_power_on;
        logic base_clock_select;
        logic [1:0] pre;
        logic [1:0] vpr;
        logic auto_bw;
        logic acq_hold;
        logic [3:0] feedback_multiplier_high;
        logic [7:0] feedback_multiplier_low;
        logic [7:0] vco_range_multiplier;
        logic [3:0] reference_divider_value;
        logic lock_s1;
        logic lock_s2;
        logic lock_q;
        logic trk_s1;
        logic trk_s2;
        logic src_q;
        logic base_clk;
        logic xclk_out;
        logic irq;
        logic pll_en;
        logic osc_en;
        logic acq_out;
        logic [11:0] fb_mult;
        logic [3:0] ref_div;
        logic [7:0] rd_data;
    } pcg_state_t;

    pcg_state_t state_reg;
    pcg_state_t state_next;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [2:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic rd_ctrl;
    logic lock_chg;
    logic flag_clr;
    logic vrs_zero;
    logic stop_all;
    logic src_now;
    logic acq_view;
    logic [11:0] mul_cat;
    logic [7:0] rd_mux;

    always_comb begin
        state_next = state_reg;
        wr_ctrl = wr_en_i && hit(addr_i, pcg_pkg::OFF_CTRL);
        rd_ctrl = rd_en_i && hit(addr_i, pcg_pkg::OFF_CTRL);
        lock_chg = state_reg.lock_s2 ^ state_reg.lock_q;
        flag_clr = rd_ctrl && !(break_state_i && !break_clear_enable_i);
        vrs_zero = (state_reg.vco_range_multiplier == pcg_pkg::VRS_ZERO);
        stop_all = stop_mode_i && !osc_run_in_stop_i;
        acq_view = state_reg.auto_bw ? state_reg.trk_s2 : state_reg.acq_hold;
        mul_cat = {state_reg.feedback_multiplier_high, state_reg.feedback_multiplier_low};

        // Lock and tracking synchronisers
        state_next.lock_s1 = lock_i;
        state_next.lock_s2 = state_reg.lock_s1;
        state_next.lock_q = state_reg.lock_s2;
        state_next.trk_s1 = loop_tracking_i;
        state_next.trk_s2 = state_reg.trk_s1;

        // Control register write
        if (wr_ctrl) begin
            state_next.pll_irq_enable = state_reg.auto_bw && wr_data_i[pcg_pkg::CTRL_IE_BIT];
            state_next.base_clock_select = wr_data_i[pcg_pkg::CTRL_BCS_BIT]
                && state_reg.pll_power_on && !vrs_zero;
            state_next.pll_power_on = wr_data_i[pcg_pkg::CTRL_ON_BIT]
                || state_reg.base_clock_select || state_next.base_clock_select;
            if (!state_reg.pll_power_on) begin
                state_next.pre = wr_data_i[pcg_pkg::CTRL_PRE_LSB +: 2];
                state_next.vpr = wr_data_i[pcg_pkg::CTRL_VPR_LSB +: 2];
            end
        end

        // Bandwidth register write
        if (wr_en_i && hit(addr_i, pcg_pkg::OFF_BW)) begin
            state_next.auto_bw = wr_data_i[pcg_pkg::BW_AUTO_BIT];
            if (!state_reg.auto_bw) begin
                state_next.acq_hold = wr_data_i[pcg_pkg::BW_ACQ_BIT];
            end
        end
        if (!state_next.auto_bw) begin
            state_next.pll_irq_enable = 1'b0;
        end

        // Programming registers, locked while the PLL runs
        if (wr_en_i && !state_reg.pll_power_on) begin
            if (hit(addr_i, pcg_pkg::OFF_MUL_HI)) begin
                state_next.feedback_multiplier_high = wr_data_i[3:0];
            end
            if (hit(addr_i, pcg_pkg::OFF_MUL_LO)) begin
                state_next.feedback_multiplier_low = wr_data_i;
            end
            if (hit(addr_i, pcg_pkg::OFF_VRS)) begin
                state_next.vco_range_multiplier = wr_data_i;
            end
            if (hit(addr_i, pcg_pkg::OFF_RDS)) begin
                state_next.reference_divider_value = wr_data_i[3:0];
            end
        end

        // Forced select clear on zero range or stop
        if (vrs_zero || stop_mode_i) begin
            state_next.base_clock_select = 1'b0;
        end

        // Lock change flag, set wins over clear
        if (!state_reg.auto_bw) begin
            state_next.pll_lock_change_flag = 1'b0;
        end else if (lock_chg) begin
            state_next.pll_lock_change_flag = 1'b1;
        end else if (flag_clr) begin
            state_next.pll_lock_change_flag = 1'b0;
        end

        // Base clock divide by two of the selected source
        src_now = state_reg.base_clock_select ? vco_clock_i : crystal_clock_i;
        state_next.src_q = src_now;
        if (stop_all) begin
            state_next.base_clk = 1'b0;
        end else if (src_now && !state_reg.src_q) begin
            state_next.base_clk = !state_reg.base_clk;
        end

        // Registered outputs; wait mode has no effect here
        state_next.osc_en = !stop_all;
        state_next.xclk_out = crystal_clock_i && !stop_all;
        state_next.pll_en = state_reg.pll_power_on && !vrs_zero && !stop_mode_i;
        state_next.irq = state_reg.pll_lock_change_flag && state_reg.pll_irq_enable
            && state_reg.auto_bw && !stop_all;
        state_next.acq_out = acq_view;
        state_next.fb_mult = (mul_cat == pcg_pkg::MUL_ZERO) ? pcg_pkg::MUL_ONE : mul_cat;
        state_next.ref_div = (state_reg.reference_divider_value == pcg_pkg::RDS_ZERO)
            ? pcg_pkg::RDS_ONE : state_reg.reference_divider_value;

        // Read data, valid only in the cycle after the strobe
        rd_mux = 8'h00;
        if (hit(addr_i, pcg_pkg::OFF_CTRL)) begin
            rd_mux = {state_reg.pll_irq_enable,
                state_reg.auto_bw && state_reg.pll_lock_change_flag,
                state_reg.pll_power_on, state_reg.base_clock_select,
                state_reg.pre, state_reg.vpr};
        end else if (hit(addr_i, pcg_pkg::OFF_BW)) begin
            rd_mux = {state_reg.auto_bw, state_reg.auto_bw && state_reg.lock_s2,
                acq_view, 5'h00};
        end else if (hit(addr_i, pcg_pkg::OFF_MUL_HI)) begin
            rd_mux = {4'h0, state_reg.feedback_multiplier_high};
        end else if (hit(addr_i, pcg_pkg::OFF_MUL_LO)) begin
            rd_mux = state_reg.feedback_multiplier_low;
        end else if (hit(addr_i, pcg_pkg::OFF_VRS)) begin
            rd_mux = state_reg.vco_range_multiplier;
        end else if (hit(addr_i, pcg_pkg::OFF_RDS)) begin
            rd_mux = {4'h0, state_reg.reference_divider_value};
        end
        state_next.rd_data = rd_en_i ? rd_mux : 8'h00;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
            state_reg.pll_power_on <= pcg_pkg::RST_ON;
            state_reg.acq_hold <= 1'b0;
            state_reg.feedback_multiplier_high <= pcg_pkg::RST_MUL_HI;
            state_reg.feedback_multiplier_low <= pcg_pkg::RST_MUL_LO;
            state_reg.vco_range_multiplier <= pcg_pkg::RST_VRS;
            state_reg.reference_divider_value <= pcg_pkg::RST_RDS;
            state_reg.fb_mult <= {pcg_pkg::RST_MUL_HI, pcg_pkg::RST_MUL_LO};
            state_reg.ref_div <= pcg_pkg::RST_RDS;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data_o = state_reg.rd_data;
    assign crystal_clock_out_o = state_reg.xclk_out;
    assign base_clock_out_o = state_reg.base_clk;
    assign pll_interrupt_out_o = state_reg.irq;
    assign pll_enable_o = state_reg.pll_en;
    assign osc_enable_o = state_reg.osc_en;
    assign auto_bandwidth_o = state_reg.auto_bw;
    assign acquisition_mode_bit_o = state_reg.acq_out;
    assign feedback_multiplier_o = state_reg.fb_mult;
    assign vco_range_multiplier_o = state_reg.vco_range_multiplier;
    assign reference_divider_value_o = state_reg.ref_div;
    assign prescale_o = state_reg.pre;
    assign vco_power_range_o = state_reg.vpr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence lock_edge_s;
        state_reg.auto_bw && (state_reg.lock_s2 != state_reg.lock_q);
    endsequence

    sequence irq_path_s;
        state_reg.pll_lock_change_flag ##1 (pll_interrupt_out_o == state_reg.pll_irq_enable
            || stop_mode_i || $past(stop_mode_i));
    endsequence

    flag_set_a: assert property (lock_edge_s |=> state_reg.pll_lock_change_flag)
        else $error("lock change did not set flag");
    irq_raise_a: assert property ((lock_edge_s ##0 (state_reg.pll_irq_enable
        && !stop_mode_i)) ##1 (state_reg.pll_irq_enable && !stop_mode_i)
        |=> pll_interrupt_out_o || !state_reg.auto_bw)
        else $error("enabled lock change gave no interrupt");
    irq_follow_a: assert property (state_reg.auto_bw && !stop_mode_i && !wr_en_i
        |-> irq_path_s or !state_reg.pll_lock_change_flag)
        else $error("interrupt output disagrees with flag");
    manual_flag_a: assert property (!state_reg.auto_bw |=> !state_reg.pll_lock_change_flag)
        else $error("flag set in manual mode");
    acq_hold_a: assert property (state_reg.auto_bw |=> $stable(state_reg.acq_hold))
        else $error("held acquisition value changed in auto mode");
    mult_lock_a: assert property (state_reg.pll_power_on |=> $stable(mul_cat))
        else $error("multiplier changed while PLL on");
    vrs_lock_a: assert property (state_reg.pll_power_on
        |=> $stable(state_reg.vco_range_multiplier))
        else $error("VCO range changed while PLL on");
    rds_lock_a: assert property (state_reg.pll_power_on
        |=> $stable(state_reg.reference_divider_value))
        else $error("divider changed while PLL on");
    vrs_zero_a: assert property (vrs_zero |=> !state_reg.base_clock_select ##0 !pll_enable_o)
        else $error("zero VCO range left select or PLL on");
    bcs_on_a: assert property (state_reg.base_clock_select |-> state_reg.pll_power_on)
        else $error("select set with PLL off");
    read_clear_a: assert property (rd_ctrl && !(break_state_i && !break_clear_enable_i)
        && !lock_chg |=> !state_reg.pll_lock_change_flag)
        else $error("control read did not clear flag");
    break_keep_a: assert property (rd_ctrl && break_state_i && !break_clear_enable_i
        && state_reg.pll_lock_change_flag && state_reg.auto_bw
        |=> state_reg.pll_lock_change_flag)
        else $error("flag lost during protected break");
    stop_quiet_a: assert property (stop_mode_i && !osc_run_in_stop_i
        |=> !crystal_clock_out_o && !base_clock_out_o && !pll_interrupt_out_o)
        else $error("outputs active in stop");
    stop_bcs_a: assert property (stop_mode_i |=> !state_reg.base_clock_select ##0 !pll_enable_o)
        else $error("select not cleared in stop");
    fb_zero_a: assert property (mul_cat == pcg_pkg::MUL_ZERO |=> feedback_multiplier_o
        == pcg_pkg::MUL_ONE)
        else $error("zero multiplier not shown as one");
    rds_zero_a: assert property (state_reg.reference_divider_value == pcg_pkg::RDS_ZERO
        |=> reference_divider_value_o == pcg_pkg::RDS_ONE)
        else $error("zero divider not shown as one");
    ie_manual_a: assert property (!state_reg.auto_bw |-> !state_reg.pll_irq_enable)
        else $error("irq enable set in manual mode");
    flag_read_a: assert property (rd_ctrl && !state_reg.auto_bw
        |=> !rd_data_o[pcg_pkg::CTRL_FLAG_BIT])
        else $error("flag read as one in manual mode");
    acq_auto_a: assert property (state_reg.auto_bw
        |=> acquisition_mode_bit_o == $past(state_reg.trk_s2))
        else $error("acq bit not from loop");
    acq_manual_a: assert property (!state_reg.auto_bw
        |=> acquisition_mode_bit_o == $past(state_reg.acq_hold))
        else $error("acq bit not from software");
    osc_stop_a: assert property (stop_all |=> !osc_enable_o)
        else $error("oscillator on in stop");
    osc_keep_a: assert property (stop_mode_i && osc_run_in_stop_i
        |=> osc_enable_o && !pll_enable_o)
        else $error("stop option not kept");
    xclk_copy_a: assert property (!stop_all
        |=> crystal_clock_out_o == $past(crystal_clock_i))
        else $error("crystal output not following");
    base_div_a: assert property (!stop_all && src_now && !state_reg.src_q
        |=> base_clock_out_o != $past(base_clock_out_o))
        else $error("base clock missed source edge");
    bcs_vrs_a: assert property (state_reg.base_clock_select |-> !vrs_zero)
        else $error("select set with zero range");
    on_held_a: assert property (state_reg.base_clock_select |=> state_reg.pll_power_on)
        else $error("PLL cleared under select");
    pre_lock_a: assert property (state_reg.pll_power_on
        |=> $stable(prescale_o) && $stable(vco_power_range_o))
        else $error("prescale changed while PLL on");
    rd_idle_a: assert property (!rd_en_i |=> rd_data_o == 8'h00)
        else $error("read data without strobe");

endmodule : pcg_top

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the PLL clock generator control block
// Assumes: Bench register model mirrors every access made through the port
// Notes: Lock flag is expected a fixed few cycles after each lock edge in auto mode
`timescale 1ns/1ps

module tb_top;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic crystal_clock_i = 1'b0;
    logic vco_clock_i = 1'b0;
    logic lock_i = 1'b0;
    logic loop_tracking_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic osc_run_in_stop_i = 1'b0;
    logic break_state_i = 1'b0;
    logic break_clear_enable_i = 1'b0;
    logic [7:0] rd_data_o;
    logic crystal_clock_out_o, base_clock_out_o, pll_interrupt_out_o;
    logic pll_enable_o, osc_enable_o, auto_bandwidth_o, acquisition_mode_bit_o;
    logic [11:0] feedback_multiplier_o;
    logic [7:0] vco_range_multiplier_o;
    logic [3:0] reference_divider_value_o;
    logic [1:0] prescale_o, vco_power_range_o;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'h2595;
    int ccnt = 0;
    int m_ie = 0, m_flag = 0, m_on = 1, m_bcs = 0, m_lo4 = 0, m_auto = 0, m_held = 0;
    int m_mh = 0, m_ml = 64, m_vr = 64, m_rds = 1;

    pcg_top #(.ADDR_W(3)) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .crystal_clock_i(crystal_clock_i), .vco_clock_i(vco_clock_i), .lock_i(lock_i),
        .loop_tracking_i(loop_tracking_i), .stop_mode_i(stop_mode_i),
        .osc_run_in_stop_i(osc_run_in_stop_i), .break_state_i(break_state_i),
        .break_clear_enable_i(break_clear_enable_i),
        .crystal_clock_out_o(crystal_clock_out_o), .base_clock_out_o(base_clock_out_o),
        .pll_interrupt_out_o(pll_interrupt_out_o), .pll_enable_o(pll_enable_o),
        .osc_enable_o(osc_enable_o), .auto_bandwidth_o(auto_bandwidth_o),
        .acquisition_mode_bit_o(acquisition_mode_bit_o),
        .feedback_multiplier_o(feedback_multiplier_o),
        .vco_range_multiplier_o(vco_range_multiplier_o),
        .reference_divider_value_o(reference_divider_value_o),
        .prescale_o(prescale_o), .vco_power_range_o(vco_power_range_o));

    // ------------------------------------------------------------
    // Clocks
    // ------------------------------------------------------------
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        ccnt <= ccnt + 1;
        if (ccnt % 4 == 3) crystal_clock_i <= ~crystal_clock_i;
        if (ccnt % 2 == 1) vco_clock_i <= ~vco_clock_i;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input int exp, input logic [15:0] got);
        cmp_count++;
        if (got !== 16'(exp)) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    function automatic int mval(input int a);
        case (a)
            0: return (m_ie << 7) | (m_flag << 6) | (m_on << 5) | (m_bcs << 4) | m_lo4;
            1: return (m_auto << 7) | ((m_auto & lock_i) << 6)
                | ((m_auto ? loop_tracking_i : m_held) << 5);
            2: return m_mh;
            3: return m_ml;
            4: return m_vr;
            5: return m_rds;
            default: return 0;
        endcase
    endfunction : mval

    task automatic wr(input int a, input int d);
        int o;
        int nb;
        @(posedge core_clk_i);
        wr_en_i <= 1'b1;
        addr_i <= 3'(a);
        wr_data_i <= 8'(d);
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
        o = m_on;
        case (a)
            0: begin
                m_ie = m_auto & d[7];
                nb = d[4] & o & (m_vr != 0);
                m_on = d[5] | m_bcs | nb;
                m_bcs = nb;
                if (!o) m_lo4 = d & 15;
            end
            1: begin
                if (!m_auto) m_held = d[5];
                m_auto = d[7];
                if (!m_auto) m_ie = 0;
                if (!m_auto) m_flag = 0;
            end
            2: if (!o) m_mh = d & 15;
            3: if (!o) m_ml = d & 255;
            4: if (!o) m_vr = d & 255;
            5: if (!o) m_rds = d & 15;
            default: ;
        endcase
    endtask : wr

    task automatic rd(input int a);
        int e;
        @(posedge core_clk_i);
        rd_en_i <= 1'b1;
        addr_i <= 3'(a);
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        e = mval(a);
        #1;
        chk($sformatf("reg%0d", a), e, {8'h00, rd_data_o});
        if (a == 0 && !(break_state_i && !break_clear_enable_i)) m_flag = 0;
    endtask : rd

    task automatic outs();
        int mul;
        repeat (2) @(posedge core_clk_i);
        #1;
        mul = (m_mh << 8) | m_ml;
        chk("mul", mul == 0 ? 1 : mul, {4'h0, feedback_multiplier_o});
        chk("vrs", m_vr, {8'h00, vco_range_multiplier_o});
        chk("rds", m_rds == 0 ? 1 : m_rds, {12'h000, reference_divider_value_o});
        chk("acq", m_auto ? loop_tracking_i : m_held, {15'h0, acquisition_mode_bit_o});
        chk("auto", m_auto, {15'h0, auto_bandwidth_o});
        chk("pll_en", m_on & (m_vr != 0) & !stop_mode_i, {15'h0, pll_enable_o});
        chk("irq", m_flag & m_ie & m_auto, {15'h0, pll_interrupt_out_o});
        chk("ctrl_lo", m_lo4, {12'h000, prescale_o, vco_power_range_o});
    endtask : outs

    task automatic flip_lock();
        @(posedge core_clk_i);
        lock_i <= ~lock_i;
        repeat (5) @(posedge core_clk_i);
        if (m_auto) m_flag = 1;
    endtask : flip_lock

    task automatic rate(input int half);
        int n = 0;
        logic p;
        p = base_clock_out_o;
        repeat (160) begin
            @(posedge core_clk_i);
            #1;
            if (base_clock_out_o && !p) n++;
            p = base_clock_out_o;
        end
        chk("base_rate", 1, {15'h0, (n >= 160 / (4 * half) - 1) && (n <= 160 / (4 * half) + 1)});
    endtask : rate

    task automatic stop_chk(input logic osc);
        logic xh = 1'b0;
        logic bh = 1'b0;
        @(posedge core_clk_i);
        osc_run_in_stop_i <= osc;
        stop_mode_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        m_bcs = 0;
        repeat (16) begin
            @(posedge core_clk_i);
            #1;
            xh = xh | crystal_clock_out_o;
            bh = bh | base_clock_out_o | pll_interrupt_out_o;
        end
        chk("xclk_run", osc, {15'h0, xh});
        if (!osc) chk("base_low", 0, {15'h0, bh});
        chk("osc_en", osc, {15'h0, osc_enable_o});
        chk("pll_stop", 0, {15'h0, pll_enable_o});
        @(posedge core_clk_i);
        stop_mode_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rd(0);
    endtask : stop_chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        $display("BAD watchdog expected done seen hang");
        stop_test();
    end

    initial begin
        int v;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 7; a++) rd(a);
        outs();
        for (int a = 2; a < 6; a++) wr(a, $random(seed));
        wr(0, 8'h2F);
        for (int a = 0; a < 6; a++) rd(a);
        wr(0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 0 : (i == 1) ? 12'hFFF : $random(seed) & 4095;
            wr(2, (v >> 8) | 8'hF0);
            wr(3, v & 255);
            wr(4, ($random(seed) & 127) | 1);
            wr(5, (i == 0) ? 0 : $random(seed) & 255);
            wr(0, $random(seed) & 15);
            outs();
            for (int a = 2; a < 6; a++) rd(a);
        end
        rate(4);
        wr(0, 8'h10);
        rd(0);
        wr(0, 8'h20);
        wr(0, 8'h30);
        rd(0);
        rate(2);
        wr(0, 8'h00);
        rd(0);
        wr(0, 8'h30);
        stop_chk(1'b0);
        stop_chk(1'b1);
        wr(0, 8'h10);
        rd(0);
        wr(0, 8'h00);
        wr(0, 8'h00);
        wr(4, 8'h00);
        wr(0, 8'h20);
        wr(0, 8'h30);
        rd(0);
        outs();
        wr(0, 8'h00);
        wr(4, 8'h40);
        wr(1, 8'h20);
        rd(1);
        outs();
        wr(1, 8'hA0);
        rd(1);
        @(posedge core_clk_i);
        loop_tracking_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        rd(1);
        outs();
        wr(1, 8'h80);
        wr(1, 8'h00);
        rd(1);
        outs();
        wr(1, 8'h80);
        wr(0, 8'hA0);
        flip_lock();
        outs();
        rd(1);
        rd(0);
        rd(0);
        wr(0, 8'h20);
        flip_lock();
        outs();
        rd(0);
        @(posedge core_clk_i);
        break_state_i <= 1'b1;
        flip_lock();
        rd(0);
        rd(0);
        @(posedge core_clk_i);
        break_clear_enable_i <= 1'b1;
        rd(0);
        rd(0);
        @(posedge core_clk_i);
        break_state_i <= 1'b0;
        break_clear_enable_i <= 1'b0;
        wr(1, 8'h00);
        flip_lock();
        rd(0);
        outs();
        stop_test();
    end
endmodule : tb_top
